// file: design/pta_arbiter.sv
/*
 * pta_arbiter: two-level bus arbiter with Wishbone register slave.
 * Assumes active-low request, frame and lock pins asynchronous to clk,
 * a classic Wishbone master on the same clock, and one clock at 250 MHz.
 */
`timescale 1ns/1ps
`include "pta_defines.svh"

// Behaviour
// - pair banks without rotation always favour the line chosen by the select bit
// - pair banks with rotation swap favoured line after every grant to them
// - disk engine bank has fixed select 0 and no rotation, not programmable
// - select 0: south bridge, master one, host favoured; select 1 reverses
// - top-level two-bit fixed mode orders disk engine and three pair winners
// - top-level rotation steps eight slots, four fixed schemes, four programmable
// - programmable slot n takes its scheme from bits 2n+1:2n
// - extension bit 0 enables top-level rotation, resets to one
// - control one bits 7:5 enable rotation of banks 3 to 1, reset 111
// - control one bits 2:0 fixed selects banks 3 to 1, zero favours upper
// - hold bit clear: host grant removed when any other request is seen
// - three-bit super agent field picks one favoured requester, zero disables
// - grant timeout counts clocks from grant until frame: 16, 4, 8, 32
// - control bit 2 gates the grant timeout
// - control bit 1 clear parks idle bus on host, set on last master
// - control bit 0 set makes locked transfer a bus lock, clear ignores lock
// - control bit 7 enables flush handshake unless strap disables it, resets one
module pta_arbiter
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [6:0] request_b,
   output logic [6:0] grant_b,
   input wire logic frame_b,
   input wire logic lock_b,
   output logic bus_lock,
   input wire logic flush_strap_b,
   input wire logic flush_request_b,
   output logic flush_ack_b,
   output logic flush_enable
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [10:0] pin_meta;
   logic [10:0] pin_sync;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pin_meta <= 11'h7FF;
         pin_sync <= 11'h7FF;
      end
      else
      begin
         pin_meta <= {flush_request_b, flush_strap_b, lock_b, frame_b, request_b};
         pin_sync <= pin_meta;
      end
   end

   wire [6:0] req_a = ~pin_sync[6:0];
   wire frame_a = ~pin_sync[7];
   wire lock_a = ~pin_sync[8];
   wire strap_a = ~pin_sync[9];
   wire flush_req_a = ~pin_sync[10];

   // ----------------------------------------
   // registers
   // ----------------------------------------
   logic [7:0] prio_one;
   logic [7:0] prio_ext;
   logic [7:0] rr_slots;
   pta_pkg::pta_ctrl_type ctrl;
   pta_pkg::pta_state_type state;
   logic [2:0] owner;
   logic [2:0] last_master;
   logic [5:0] wait_cnt;
   logic [2:0] slot;
   logic [2:0] flip;
   logic bus_locked;
   logic [1:0] strap_cnt;
   logic strap_low;

   wire wb_req = wb_cyc_i & wb_stb_i;
   wire wb_wr = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
   wire [7:0] wdat = wb_dat_i[7:0];

   // writes land at the edge where the master samples ack
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         prio_one <= `PTA_RST_PRIO;
         prio_ext <= `PTA_RST_EXT;
         rr_slots <= `PTA_RST_SLOT;
         ctrl <= `PTA_RST_CTRL;
      end
      else if (wb_wr)
      begin
         if (wb_adr_i == `PTA_OFS_PRIO)
            prio_one <= wdat;
         if (wb_adr_i == `PTA_OFS_EXT)
            prio_ext <= wdat;
         if (wb_adr_i == `PTA_OFS_SLOT)
            rr_slots <= wdat;
         if (wb_adr_i == `PTA_OFS_CTRL)
            ctrl <= wdat;
      end
   end

   wire [31:0] stat_word = {21'h0, slot, flush_enable, bus_locked, state, ~(&grant_b), owner};
   wire [31:0] rdata =
      (wb_adr_i == `PTA_OFS_PRIO) ? {24'h0, prio_one} :
      (wb_adr_i == `PTA_OFS_EXT) ? {24'h0, prio_ext} :
      (wb_adr_i == `PTA_OFS_SLOT) ? {24'h0, rr_slots} :
      (wb_adr_i == `PTA_OFS_CTRL) ? {24'h0, ctrl} :
      (wb_adr_i == `PTA_OFS_STAT) ? stat_word : 32'h0;

   // unmapped offsets still ack, reading zero, so no master hangs
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end
      else
      begin
         wb_ack_o <= wb_req & ~wb_ack_o;
         wb_dat_o <= rdata;
      end
   end

   // ----------------------------------------
   // level 1: pair banks
   // ----------------------------------------
   localparam logic [2:0] UPPER [3] = '{`PTA_ID_SB, `PTA_ID_M1, `PTA_ID_HOST};
   localparam logic [2:0] LOWER [3] = '{`PTA_ID_M0, `PTA_ID_M2, `PTA_ID_M3};

   logic [6:0] elig;
   logic [2:0] pair_req;
   logic [2:0] pair_pick [3];
   logic [2:0] pair_sel;
   logic [2:0] pair_rot;

   genvar k;
   generate
      for (k = 0; k < 3; k++)
      begin : g_pair
         assign pair_rot[k] = prio_one[`PTA_PRIO_ROT_LSB + k];
         // rotation replaces the fixed select by the toggling favourite
         assign pair_sel[k] = pair_rot[k] ? flip[k] : prio_one[k];
         assign pair_req[k] = elig[UPPER[k]] | elig[LOWER[k]];
         assign pair_pick[k] = pair_sel[k] ?
            (elig[LOWER[k]] ? LOWER[k] : UPPER[k]) :
            (elig[UPPER[k]] ? UPPER[k] : LOWER[k]);
      end
   endgenerate

   // ----------------------------------------
   // level 2: top-level bank
   // ----------------------------------------
   wire rot4 = prio_ext[`PTA_EXT_ROT_BIT];
   wire [1:0] fpmod = prio_one[`PTA_PRIO_FPMOD_LSB +: 2];
   wire [1:0] slot_scheme = slot[2] ? rr_slots[{slot[1:0], 1'b0} +: 2] : slot[1:0];
   wire [1:0] scheme = rot4 ? slot_scheme : fpmod;
   // disk engine has no bank logic: its select and rotation are constant zero
   wire [3:0] cand_req = {pair_req, elig[`PTA_ID_DISK]};
   wire [2:0] cand_id [4] = '{`PTA_ID_DISK, pair_pick[0], pair_pick[1], pair_pick[2]};

   logic [2:0] top_pick;
   logic [1:0] pos;

   always_comb
   begin
      top_pick = `PTA_ID_DISK;
      pos = 2'h0;
      for (int i = 3; i >= 0; i--)
      begin
         pos = scheme + i[1:0];
         if (cand_req[pos])
            top_pick = cand_id[pos];
      end
   end

   // ----------------------------------------
   // super agent and winner
   // ----------------------------------------
   wire [2:0] sa_code = prio_ext[`PTA_EXT_SA_LSB +: 3];
   logic [2:0] sa_id;

   always_comb
   begin
      case (sa_code)
         3'h1: sa_id = `PTA_ID_DISK;
         3'h2: sa_id = `PTA_ID_SB;
         3'h3: sa_id = `PTA_ID_HOST;
         3'h4: sa_id = `PTA_ID_M0;
         3'h5: sa_id = `PTA_ID_M1;
         3'h6: sa_id = `PTA_ID_M2;
         3'h7: sa_id = `PTA_ID_M3;
         default: sa_id = `PTA_ID_DISK;
      endcase
   end

   wire sa_hit = (sa_code != 3'h0) & elig[sa_id];
   wire [2:0] winner = sa_hit ? sa_id : top_pick;
   wire any_elig = |elig;

   // a held bus lock shuts out everyone but its owner
   assign elig = (bus_locked ? (req_a & (7'h01 << owner)) : req_a);

   // ----------------------------------------
   // grant sequencing
   // ----------------------------------------
   logic [5:0] ato_limit;

   always_comb
   begin
      case (ctrl.grant_timeout_sel)
         2'h0: ato_limit = `PTA_ATO_SEL0;
         2'h1: ato_limit = `PTA_ATO_SEL1;
         2'h2: ato_limit = `PTA_ATO_SEL2;
         default: ato_limit = `PTA_ATO_SEL3;
      endcase
   end

   wire others_req = |(req_a & ~(7'h01 << `PTA_ID_HOST));
   wire host_preempt = (owner == `PTA_ID_HOST) & ~prio_ext[`PTA_EXT_HOLD_BIT] & others_req;
   wire timed_out = ctrl.grant_timeout_enable & (wait_cnt == ato_limit - 6'h01) & ~frame_a;
   wire issue = (state == pta_pkg::PTA_IDLE) & any_elig;
   wire owner_done = ~req_a[owner];
   wire [2:0] park_id = ctrl.park_last ? last_master : `PTA_ID_HOST;

   pta_pkg::pta_state_type next_state;
   logic [6:0] next_grant_b;

   always_comb
   begin
      next_state = state;
      next_grant_b = grant_b;
      case (state)
         pta_pkg::PTA_IDLE:
         begin
            if (any_elig)
            begin
               next_state = pta_pkg::PTA_GRANTED;
               next_grant_b = ~(7'h01 << winner);
            end
            else
               next_grant_b = ~(7'h01 << park_id);
         end
         pta_pkg::PTA_GRANTED:
         begin
            if (frame_a)
               next_state = pta_pkg::PTA_BUSY;
            else if (timed_out | host_preempt | owner_done)
            begin
               // grant withdrawn now, a fresh winner is chosen next clock
               next_state = pta_pkg::PTA_IDLE;
               next_grant_b = 7'h7F;
            end
         end
         pta_pkg::PTA_BUSY:
         begin
            if (host_preempt | (owner_done & ~bus_locked))
            begin
               next_state = pta_pkg::PTA_DRAIN;
               next_grant_b = 7'h7F;
            end
         end
         pta_pkg::PTA_DRAIN:
         begin
            if (~frame_a)
               next_state = pta_pkg::PTA_IDLE;
         end
         default:
         begin
            next_state = pta_pkg::PTA_IDLE;
            next_grant_b = 7'h7F;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         state <= pta_pkg::PTA_IDLE;
         grant_b <= 7'h7F;
         owner <= `PTA_ID_HOST;
         last_master <= `PTA_ID_HOST;
      end
      else
      begin
         state <= next_state;
         grant_b <= next_grant_b;
         if (issue)
         begin
            owner <= winner;
            last_master <= winner;
         end
      end
   end

   // ----------------------------------------
   // timeout counter and rotation state
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         wait_cnt <= 6'h0;
      else if (state == pta_pkg::PTA_GRANTED)
         wait_cnt <= wait_cnt + 6'h01;
      else
         wait_cnt <= 6'h0;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         slot <= 3'h0;
         flip <= 3'h0;
      end
      else if (issue)
      begin
         if (rot4)
            slot <= slot + 3'h1;
         for (int b = 0; b < 3; b++)
            if (pair_rot[b] & ((winner == UPPER[b]) | (winner == LOWER[b])))
               flip[b] <= ~pair_sel[b];
      end
   end

   // ----------------------------------------
   // bus lock and flush handshake
   // ----------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         bus_locked <= 1'b0;
         bus_lock <= 1'b0;
      end
      else
      begin
         bus_locked <= ctrl.lock_enable & lock_a & (bus_locked | (state == pta_pkg::PTA_BUSY));
         bus_lock <= ctrl.lock_enable & lock_a & (bus_locked | (state == pta_pkg::PTA_BUSY));
      end
   end

   // strap read once, when its synchroniser holds the pin; the pin is free for other use later
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         strap_cnt <= 2'h0;
         strap_low <= 1'b0;
         flush_enable <= 1'b0;
         flush_ack_b <= 1'b1;
      end
      else
      begin
         if (strap_cnt != 2'h3)
            strap_cnt <= strap_cnt + 2'h1;
         if (strap_cnt == 2'h2)
            strap_low <= strap_a;
         flush_enable <= ctrl.guaranteed_access_enable & ~strap_low & (strap_cnt == 2'h3);
         flush_ack_b <= ~(flush_enable & flush_req_a);
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   grant_one_hot_a: assert property ($onehot0(~grant_b))
      else $error("more than one grant");
   timeout_drop_a: assert property ((state == pta_pkg::PTA_GRANTED) && timed_out |=> (&grant_b))
      else $error("grant kept after timeout");
   timeout_bound_a: assert property ((state == pta_pkg::PTA_GRANTED) && ctrl.grant_timeout_enable
      |-> wait_cnt < ato_limit)
      else $error("grant waited past limit");
   host_preempt_a: assert property ((state == pta_pkg::PTA_BUSY) && host_preempt |=> grant_b[5])
      else $error("host grant not removed");
   park_host_a: assert property ((state == pta_pkg::PTA_IDLE) && !any_elig && !ctrl.park_last
      |=> grant_b == 7'h5F)
      else $error("idle bus not parked on host");
   super_agent_a: assert property (issue && sa_hit |=> owner == $past(sa_id))
      else $error("super agent not served");
   slot_step_a: assert property (issue && rot4 |=> slot == $past(slot) + 3'h1)
      else $error("round robin slot stuck");
   fixed_pair_a: assert property (!pair_rot[0] && elig[`PTA_ID_SB] && elig[`PTA_ID_M0]
      |-> pair_pick[0] == (prio_one[0] ? `PTA_ID_M0 : `PTA_ID_SB))
      else $error("bank one ignores its select");
   lock_ignore_a: assert property (!ctrl.lock_enable |=> !bus_locked)
      else $error("lock honoured while disabled");
   wb_ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

endmodule // pta_arbiter

// file: design/pta_defines.svh
/*
 * pta_defines.svh: offsets, field positions, reset values and timeout counts
 * of the two-level bus arbiter. Assumes a Wishbone byte address and 32-bit data.
 */
`ifndef PTA_DEFINES_SVH
`define PTA_DEFINES_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define PTA_OFS_PRIO 8'h00
`define PTA_OFS_EXT 8'h04
`define PTA_OFS_SLOT 8'h08
`define PTA_OFS_CTRL 8'h0C
`define PTA_OFS_STAT 8'h10

// ----------------------------------------
// reset values
// ----------------------------------------
`define PTA_RST_PRIO 8'hE0
`define PTA_RST_EXT 8'h01
`define PTA_RST_SLOT 8'h00
`define PTA_RST_CTRL 8'h80

// ----------------------------------------
// field positions
// ----------------------------------------
`define PTA_PRIO_ROT_LSB 5
`define PTA_PRIO_FPMOD_LSB 3
`define PTA_EXT_HOLD_BIT 4
`define PTA_EXT_SA_LSB 1
`define PTA_EXT_ROT_BIT 0

// ----------------------------------------
// requester indexes
// ----------------------------------------
`define PTA_ID_DISK 3'h0
`define PTA_ID_SB 3'h1
`define PTA_ID_M0 3'h2
`define PTA_ID_M1 3'h3
`define PTA_ID_M2 3'h4
`define PTA_ID_HOST 3'h5
`define PTA_ID_M3 3'h6

// ----------------------------------------
// grant timeout limits in clocks
// ----------------------------------------
`define PTA_ATO_SEL0 6'h10
`define PTA_ATO_SEL1 6'h04
`define PTA_ATO_SEL2 6'h08
`define PTA_ATO_SEL3 6'h20

`endif

// file: design/pta_pkg.sv
/*
 * pta_pkg: types of the two-level bus arbiter.
 * Assumes pta_defines.svh for all numbers but the state codes and control field layout set here.
 */
package pta_pkg;

   typedef enum logic [1:0]
   {
      PTA_IDLE = 2'b00,
      PTA_GRANTED = 2'b01,
      PTA_BUSY = 2'b10,
      PTA_DRAIN = 2'b11
   } pta_state_type;

   typedef struct packed
   {
      logic guaranteed_access_enable;
      logic [1:0] reserved;
      logic [1:0] grant_timeout_sel;
      logic grant_timeout_enable;
      logic park_last;
      logic lock_enable;
   } pta_ctrl_type;

endpackage

// file: bench/pta_master_model.sv
/*
 * pta_master_model: behavioural bus masters facing the arbiter's grants.
 * Assumes active-low grants from the arbiter and a pulled-up frame line.
 */
`timescale 1ns/1ps

module pta_master_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [6:0] want,
   input wire logic [5:0] frame_delay,
   input wire logic no_frame,
   input wire logic [6:0] grant_b,
   output logic [6:0] request_b,
   output logic frame_b
);
   logic [6:0] done;
   logic [6:0] cur;
   logic [5:0] wait_cnt;
   logic [1:0] burst;
   wire logic [6:0] owner = ~grant_b & want & ~done;

   // a master asks only while it still needs the bus
   assign request_b = ~(want & ~done);

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         done <= 7'h00;
         cur <= 7'h00;
         wait_cnt <= 6'h00;
         burst <= 2'h0;
         frame_b <= 1'b1;
      end
      else if (burst != 2'h0)
      begin
         burst <= burst - 2'h1;
         if (burst == 2'h1)
         begin
            // released frame goes back to its pull-up level
            frame_b <= 1'b1;
            done <= (done & want) | cur;
         end
      end
      else
      begin
         done <= done & want;
         // frame follows the grant after a set wait, unless told to stall
         if (owner != 7'h00 && !no_frame)
         begin
            wait_cnt <= wait_cnt + 6'h01;
            if (wait_cnt == frame_delay)
            begin
               frame_b <= 1'b0;
               burst <= 2'h2;
               cur <= owner;
               wait_cnt <= 6'h00;
            end
         end
         else
            wait_cnt <= 6'h00;
      end
   end
endmodule // pta_master_model

// file: bench/tb_pta_arbiter.sv
/*
 * tb_pta_arbiter: self-checking bench for the two-level bus arbiter.
 * Assumes pta_master_model on the request side and a classic Wishbone master here.
 */
`timescale 1ns/1ps
`include "pta_defines.svh"
`define CHK(w, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
$display("CHECK FAILED %s expected %0h seen %0h", w, e, g); end end

module tb_pta_arbiter;
   logic clk;
   logic rst_b;
   logic wb_cyc, wb_stb, wb_we, wb_ack_o;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat, wb_dat_o;
   logic frame_b, bus_lock, flush_request_b, flush_ack_b, flush_enable, no_frame, lock_b;
   logic [6:0] request_b, grant_b, want;
   logic [5:0] frame_delay;
   logic [7:0] q;
   int miscompares = 0;
   int n_compared = 0;

   always #2 clk = ~clk;

   pta_arbiter uut
   (
      .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .request_b(request_b), .grant_b(grant_b), .frame_b(frame_b),
      .lock_b(lock_b), .bus_lock(bus_lock), .flush_strap_b(1'b1), .flush_request_b(flush_request_b),
      .flush_ack_b(flush_ack_b), .flush_enable(flush_enable)
   );

   pta_master_model masters
   (
      .clk(clk), .rst_b(rst_b), .want(want), .frame_delay(frame_delay), .no_frame(no_frame),
      .grant_b(grant_b), .request_b(request_b), .frame_b(frame_b)
   );

   // ----------------------------------------
   // bus and arbitration helpers
   // ----------------------------------------
   task automatic give_verdict();
      if (miscompares == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // no fixed answer time assumed: wait for ack under a bound
   task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] din, output logic [7:0] dout);
      int n;
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= {24'h000000, din};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      dout = wb_dat_o[7:0];
      `CHK("ack", 1'b1, wb_ack_o)
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask

   // one contest: the first granted requester wins, then all requests drop
   task automatic round(input logic [6:0] w, output int idx);
      int n;
      idx = 7;
      want <= w;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while ((~grant_b & w) == 7'h00 && n < 40);
      for (int i = 0; i < 7; i++)
         if (grant_b[i] === 1'b0 && w[i])
            idx = i;
      want <= 7'h00;
      repeat (12) @(posedge clk);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset();
      `CHK("idle park", 7'h5F, grant_b)
      `CHK("flush enable", 1'b1, flush_enable)
      wb(0, `PTA_OFS_PRIO, 8'h00, q);
      `CHK("prio reset", 8'hE0, q)
      wb(0, `PTA_OFS_EXT, 8'h00, q);
      `CHK("ext reset", 8'h01, q)
      wb(0, `PTA_OFS_SLOT, 8'h00, q);
      `CHK("slot reset", 8'h00, q)
      wb(0, `PTA_OFS_CTRL, 8'h00, q);
      `CHK("ctrl reset", 8'h80, q)
      wb(1, 8'h14, 8'hFF, q);
      wb(0, 8'h14, 8'h00, q);
      `CHK("unmapped", 8'h00, q)
      wb(1, `PTA_OFS_SLOT, 8'hA5, q);
      wb(0, `PTA_OFS_SLOT, 8'h00, q);
      `CHK("slot rw", 8'hA5, q)
      wb(1, `PTA_OFS_SLOT, 8'h00, q);
   endtask

   // pair banks one and two without rotation, each select, twice in a row
   task automatic test_fixed();
      int idx;
      wb(1, `PTA_OFS_EXT, 8'h00, q);
      for (int b = 0; b < 2; b++)
         for (int s = 0; s < 2; s++)
            for (int r = 0; r < 2; r++)
            begin
               wb(1, `PTA_OFS_PRIO, 8'(s << b), q);
               round(b ? 7'h18 : 7'h06, idx);
               `CHK("pair winner", 1 + 2 * b + s, idx)
            end
      round(7'h03, idx);
      `CHK("disk over bank one", 0, idx)
   endtask

   task automatic test_rotate();
      int a, b, c;
      frame_delay <= 6'h03;
      wb(1, `PTA_OFS_PRIO, 8'h20, q);
      round(7'h06, a);
      round(7'h06, b);
      round(7'h06, c);
      `CHK("rotation swap", 1, (a != b))
      `CHK("rotation back", a, c)
      frame_delay <= 6'h01;
   endtask

   task automatic test_top();
      int idx, wins;
      for (int m = 0; m < 4; m++)
      begin
         wb(1, `PTA_OFS_PRIO, 8'(m << 3), q);
         round(7'h55, idx);
         `CHK("top fixed mode", 2 * m, idx)
      end
      // all programmable slots on scheme 01: eight grants give bank one five
      wb(1, `PTA_OFS_SLOT, 8'h55, q);
      wb(1, `PTA_OFS_EXT, 8'h01, q);
      wins = 0;
      repeat (8)
      begin
         round(7'h55, idx);
         if (idx == 2)
            wins++;
      end
      `CHK("slot wins", 5, wins)
      wb(1, `PTA_OFS_SLOT, 8'h00, q);
   endtask

   task automatic test_super();
      int idx;
      int sa_win [8] = '{0, 0, 1, 5, 2, 3, 4, 6};
      wb(1, `PTA_OFS_PRIO, 8'h00, q);
      // host code left out: a parked host would win before any contest
      for (int c = 0; c < 8; c++)
         if (c != 3)
         begin
            wb(1, `PTA_OFS_EXT, 8'(c << 1), q);
            round(7'h5F, idx);
            `CHK("super agent", sa_win[c], idx)
         end
      wb(1, `PTA_OFS_EXT, 8'h00, q);
   endtask

   task automatic test_timeout();
      int n;
      int lim [4] = '{16, 4, 8, 32};
      no_frame <= 1'b1;
      for (int s = 0; s < 5; s++)
      begin
         wb(1, `PTA_OFS_CTRL, (s < 4) ? 8'(8'h84 | (s << 3)) : 8'h80, q);
         want <= 7'h08;
         n = 0;
         while (grant_b[3] !== 1'b0 && n < 40)
         begin
            @(posedge clk);
            n++;
         end
         n = 0;
         while (grant_b[3] === 1'b0 && n < 60)
         begin
            @(posedge clk);
            n++;
         end
         if (s < 4)
            `CHK("timeout clocks", lim[s], n)
         else
            `CHK("no timeout", 60, n)
         want <= 7'h00;
         repeat (12) @(posedge clk);
      end
   endtask

   task automatic test_host();
      int n;
      want <= 7'h20;
      repeat (8) @(posedge clk);
      `CHK("host granted", 7'h5F, grant_b)
      want <= 7'h28;
      n = 0;
      while (grant_b[3] !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("host preempted", 7'h77, grant_b)
      want <= 7'h00;
      no_frame <= 1'b0;
      repeat (12) @(posedge clk);
   endtask

   // locked transfer keeps the bus for its owner until lock goes away
   task automatic test_lock();
      int n;
      wb(1, `PTA_OFS_CTRL, 8'h81, q);
      lock_b <= 1'b0;
      want <= 7'h08;
      n = 0;
      while (grant_b[3] !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      repeat (8) @(posedge clk);
      `CHK("bus lock", 1'b1, bus_lock)
      want <= 7'h18;
      repeat (10) @(posedge clk);
      `CHK("locked owner", 7'h77, grant_b)
      lock_b <= 1'b1;
      n = 0;
      while (grant_b[4] !== 1'b0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      `CHK("lock released", 7'h6F, grant_b)
      `CHK("bus unlock", 1'b0, bus_lock)
      want <= 7'h00;
      wb(1, `PTA_OFS_CTRL, 8'h80, q);
      repeat (12) @(posedge clk);
   endtask

   task automatic test_park_flush();
      int idx;
      wb(1, `PTA_OFS_CTRL, 8'h82, q);
      round(7'h10, idx);
      `CHK("park last", 7'h6F, grant_b)
      wb(1, `PTA_OFS_CTRL, 8'h80, q);
      repeat (6) @(posedge clk);
      `CHK("park host", 7'h5F, grant_b)
      flush_request_b <= 1'b0;
      repeat (4) @(posedge clk);
      `CHK("flush ack", 1'b0, flush_ack_b)
      flush_request_b <= 1'b1;
      wb(1, `PTA_OFS_CTRL, 8'h00, q);
      repeat (3) @(posedge clk);
      `CHK("flush off", 1'b0, flush_enable)
   endtask

   initial
   begin
      clk = 1'b0;
      rst_b = 1'b0;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 8'h00;
      wb_sel = 4'hF;
      wb_dat = 32'h00000000;
      want = 7'h00;
      frame_delay = 6'h01;
      no_frame = 1'b0;
      flush_request_b = 1'b1;
      lock_b = 1'b1;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (6) @(posedge clk);
      test_reset();
      test_fixed();
      test_rotate();
      test_top();
      test_super();
      test_timeout();
      test_host();
      test_lock();
      test_park_flush();
      give_verdict();
   end

   // whole run needs about a thousand clocks
   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      give_verdict();
   end
endmodule // tb_pta_arbiter
